//--- mch_consts.vh
`ifndef MCH_CONSTS_VH
`define MCH_CONSTS_VH
// Summary of operation
// - Remote config response goes back only when the request frame identifier is non-zero.
// - No remote response frame is produced when the destination was unreachable.
// - Received remote response becomes a host frame with status and queried value.
// - Remote writes take effect only via apply bit, apply command, or save then reset.
// - With API setting zero, destination high and low settings give the unicast target.
// - Aggregate parameter 0xFFFE matches no node, so no destination changes.
// - A receiver in API operation that updated its destination emits frame type 0x8E.
// - Every aggregate receiver installs a route toward the sender for later unicasts.
// - Link test request payload is 12 bytes: target, packet size, iteration count.
// - Iteration count must be 1 to 4000; otherwise it is an invalid parameter.
// - After all test packets the tester sends results to cluster 0x0094, endpoint 0xE6.
// - A received link test result goes to the host as frame type 0x91.
// - Result payload: address, size, iterations, acked, retries, result, limit, three levels.
// - Retry field totals MAC retries spent on all test packets.
// - Result code is 0x00 on success and 0x03 for an invalid parameter.
// - Retry limit field reports the maximum MAC retries allowed per packet.
// - Signal fields hold strongest, weakest and average signal seen during the test.
// - Broadcast destination is high 0 and low 0xFFFF.
// - Radio payload is at most 256 bytes, bounding the test packet size.
`define MCH_FID_NONE 8'h00
`define MCH_ST_OK 8'h00
`define MCH_ST_BAD_CMD 8'h02
`define MCH_FT_REMOTE_RSP 8'h80
`define MCH_FT_AGG_UPDATE 8'h8E
`define MCH_FT_EXPLICIT_RX 8'h91
`define MCH_CL_LT_REQ 16'h0014
`define MCH_CL_LT_RES 16'h0094
`define MCH_EP_DIAG 8'hE6
`define MCH_LT_REQ_BYTES 4'hC
`define MCH_LT_RES_BYTES 21
`define MCH_ITER_MIN 16'h0001
`define MCH_ITER_MAX 16'h0FA0
`define MCH_SIZE_MIN 16'h0001
`define MCH_SIZE_MAX 16'h0100
`define MCH_RES_OK 8'h00
`define MCH_RES_BAD_PARAM 8'h03
`define MCH_AGG_NO_MATCH 64'h000000000000FFFE
`define MCH_BCAST_ADDR 64'h000000000000FFFF
`define MCH_DH_RST 32'h00000000
`define MCH_DL_RST 32'h0000FFFF
`define MCH_API_RST 8'h00
`define MCH_CMD_SET_DH 3'h1
`define MCH_CMD_SET_DL 3'h2
`define MCH_CMD_SET_API 3'h3
`define MCH_CMD_APPLY 3'h4
`define MCH_CMD_WRITE_NV 3'h5
`define MCH_CMD_SW_RESET 3'h6
`define MCH_REQ_DEST 95:32
`define MCH_REQ_SIZE 31:16
`define MCH_REQ_ITER 15:0
`define MCH_RSSI_INIT_PEAK 8'hFF
`define MCH_RSSI_INIT_LOW 8'h00
`endif

//--- mch_serializer.v
// Shifts a loaded payload out one byte at a time, most significant byte first
module mch_serializer #(
  parameter NBYTES = 21
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Payload load
  input wire load_i,
  input wire [8*NBYTES-1:0] data_i,
  // Byte stream out
  input wire ready_i,
  output reg valid_o,
  output wire [7:0] byte_o,
  output reg last_o
);
  localparam [7:0] LAST_IDX = NBYTES - 1;
  reg [8*NBYTES-1:0] shift_reg;
  reg [7:0] cnt_reg;

  assign byte_o = shift_reg[8*NBYTES-1 -: 8];

  // Load is ignored while a payload is still draining
  always @(posedge clk_i) begin
    if (rst_i) begin
      shift_reg <= {8*NBYTES{1'b0}};
      cnt_reg <= 8'h00;
      valid_o <= 1'b0;
      last_o <= 1'b0;
    end else if (load_i && !valid_o) begin
      shift_reg <= data_i;
      cnt_reg <= LAST_IDX;
      valid_o <= 1'b1;
      last_o <= (LAST_IDX == 8'h00);
    end else if (valid_o && ready_i) begin
      if (cnt_reg == 8'h00) begin
        valid_o <= 1'b0;
        last_o <= 1'b0;
      end else begin
        shift_reg <= shift_reg << 8;
        cnt_reg <= cnt_reg - 8'h01;
        last_o <= (cnt_reg == 8'h01);
      end
    end
  end
endmodule // mch_serializer

//--- mch_divider.v
// Restoring divider, one quotient bit per cycle
module mch_divider #(
  parameter NW = 24,
  parameter DW = 16
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Operands
  input wire start_i,
  input wire [NW-1:0] num_i,
  input wire [DW-1:0] den_i,
  // Result
  output reg done_o,
  output reg [NW-1:0] quo_o
);
  localparam [5:0] STEPS = NW;
  reg [DW:0] rem_reg;
  reg [DW-1:0] den_reg;
  reg [5:0] cnt_reg;
  wire [DW:0] trial = {rem_reg[DW-1:0], quo_o[NW-1]};
  wire [DW:0] diff = trial - {1'b0, den_reg};

  // Sign bit of the trial difference decides each quotient bit
  always @(posedge clk_i) begin
    if (rst_i) begin
      rem_reg <= {(DW+1){1'b0}};
      den_reg <= {DW{1'b0}};
      cnt_reg <= 6'h00;
      quo_o <= {NW{1'b0}};
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && cnt_reg == 6'h00) begin
        rem_reg <= {(DW+1){1'b0}};
        den_reg <= den_i;
        quo_o <= num_i;
        cnt_reg <= STEPS;
      end else if (cnt_reg != 6'h00) begin
        rem_reg <= diff[DW] ? trial : diff;
        quo_o <= {quo_o[NW-2:0], ~diff[DW]};
        cnt_reg <= cnt_reg - 6'h01;
        done_o <= (cnt_reg == 6'h01);
      end
    end
  end
endmodule // mch_divider

//--- mch_handler.v
`include "mch_consts.vh"

// Commissioning frame handler: remote settings, aggregate routes and link tests
module mch_handler (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Remote configuration request from the radio
  input wire rcr_valid_i,
  input wire [7:0] rcr_frame_id_i,
  input wire [63:0] rcr_src_i,
  input wire rcr_apply_i,
  input wire [2:0] rcr_cmd_i,
  input wire rcr_has_param_i,
  input wire [31:0] rcr_param_i,
  // Remote configuration response to the radio
  output reg rsp_tx_valid_o,
  output reg [63:0] rsp_tx_dest_o,
  output reg [7:0] rsp_tx_frame_id_o,
  output reg [7:0] rsp_tx_status_o,
  output reg [31:0] rsp_tx_value_o,
  // Remote response arriving for our own request
  input wire rrsp_valid_i,
  input wire rrsp_unreachable_i,
  input wire [7:0] rrsp_frame_id_i,
  input wire [7:0] rrsp_status_i,
  input wire [31:0] rrsp_value_i,
  // Frames to the host serial port
  output reg host_valid_o,
  output reg [7:0] host_type_o,
  output reg [7:0] host_frame_id_o,
  output reg [7:0] host_status_o,
  output reg [63:0] host_value_o,
  // Aggregate route command from the host
  input wire agg_cmd_valid_i,
  input wire [63:0] agg_cmd_param_i,
  // Aggregate broadcast to the radio
  output reg agg_tx_valid_o,
  output reg [63:0] agg_tx_dest_o,
  output reg [63:0] agg_tx_param_o,
  // Aggregate broadcast from the radio
  input wire agg_rx_valid_i,
  input wire [63:0] agg_rx_src_i,
  input wire [63:0] agg_rx_param_i,
  // Routing table write
  output reg route_wr_o,
  output reg [63:0] route_dest_o,
  // Active settings
  output reg [31:0] dest_addr_high_o,
  output reg [31:0] dest_addr_low_o,
  output reg [7:0] api_operation_setting_o,
  output reg ucast_target_valid_o,
  output reg [63:0] ucast_target_o,
  // Link test request bytes from the radio
  input wire ltq_valid_i,
  input wire [7:0] ltq_byte_i,
  input wire ltq_last_i,
  input wire [63:0] ltq_src_i,
  input wire [15:0] ltq_cluster_i,
  input wire [7:0] ltq_endpoint_i,
  // Test packet engine
  output reg tp_send_o,
  output reg [63:0] tp_dest_o,
  output reg [15:0] tp_size_o,
  input wire tp_done_i,
  input wire tp_acked_i,
  input wire [7:0] tp_retries_i,
  input wire [7:0] tp_rssi_i,
  input wire [7:0] mac_retry_limit_i,
  // Link test result bytes to the radio
  input wire res_ready_i,
  output wire res_valid_o,
  output wire [7:0] res_byte_o,
  output wire res_last_o,
  output reg [63:0] res_dest_o,
  output reg [15:0] res_cluster_o,
  output reg [7:0] res_endpoint_o,
  // Link test result arriving from the radio
  input wire ltr_valid_i,
  input wire [63:0] ltr_src_i,
  input wire [15:0] ltr_cluster_i,
  input wire [7:0] ltr_endpoint_i,
  // Status
  output reg busy_o
);
  localparam [5:0] S_IDLE = 6'b000001;
  localparam [5:0] S_SEND = 6'b000010;
  localparam [5:0] S_WAIT = 6'b000100;
  localparam [5:0] S_DIV = 6'b001000;
  localparam [5:0] S_LOAD = 6'b010000;
  localparam [5:0] S_OUT = 6'b100000;

  // Pending, saved and active settings
  reg [31:0] p_dh_reg, p_dl_reg, nv_dh_reg, nv_dl_reg;
  reg [7:0] p_api_reg, nv_api_reg;
  reg [31:0] p_dh_next, p_dl_next, a_dh_next, a_dl_next, nv_dh_next, nv_dl_next;
  reg [7:0] p_api_next, a_api_next, nv_api_next, st_next;
  reg [31:0] val_next;
  reg apply_now;

  // Link test state
  reg [5:0] state_reg;
  reg [95:0] req_reg;
  reg [3:0] nbytes_reg;
  reg [63:0] lt_dest_reg;
  reg [15:0] lt_size_reg, lt_iter_reg, sent_reg, succ_reg, retry_reg;
  reg [7:0] result_reg, peak_reg, low_reg, mean_reg;
  reg [23:0] rssi_sum_reg;
  reg div_go_reg, ser_load_reg;
  wire div_done;
  wire [23:0] div_quo;

  wire [63:0] dest_now = {dest_addr_high_o, dest_addr_low_o};
  // Reserved no-match value is excluded even if a node holds it
  wire agg_hit = agg_rx_valid_i && agg_rx_param_i == dest_now
                 && agg_rx_param_i != `MCH_AGG_NO_MATCH;
  wire [95:0] req_full = {req_reg[87:0], ltq_byte_i};
  wire ltq_hit = ltq_valid_i && ltq_last_i && state_reg == S_IDLE
                 && ltq_cluster_i == `MCH_CL_LT_REQ && ltq_endpoint_i == `MCH_EP_DIAG;
  wire ltq_len_ok = (nbytes_reg + 4'h1) == `MCH_LT_REQ_BYTES;
  wire iter_ok = req_full[`MCH_REQ_ITER] >= `MCH_ITER_MIN
                 && req_full[`MCH_REQ_ITER] <= `MCH_ITER_MAX;
  wire size_ok = req_full[`MCH_REQ_SIZE] >= `MCH_SIZE_MIN
                 && req_full[`MCH_REQ_SIZE] <= `MCH_SIZE_MAX;
  wire [15:0] sent_next = sent_reg + 16'h0001;
  wire [16:0] retry_sum = {1'b0, retry_reg} + {9'h000, tp_retries_i};

  // Remote setting writes land in the pending copy; active copy moves only on apply, software reset or an aggregate match
  always @* begin
    p_dh_next = p_dh_reg;
    p_dl_next = p_dl_reg;
    p_api_next = p_api_reg;
    a_dh_next = dest_addr_high_o;
    a_dl_next = dest_addr_low_o;
    a_api_next = api_operation_setting_o;
    nv_dh_next = nv_dh_reg;
    nv_dl_next = nv_dl_reg;
    nv_api_next = nv_api_reg;
    st_next = `MCH_ST_OK;
    val_next = 32'h00000000;
    apply_now = 1'b0;
    if (rcr_valid_i) begin
      case (rcr_cmd_i)
        `MCH_CMD_SET_DH: begin
          if (rcr_has_param_i) p_dh_next = rcr_param_i;
          val_next = dest_addr_high_o;
        end
        `MCH_CMD_SET_DL: begin
          if (rcr_has_param_i) p_dl_next = rcr_param_i;
          val_next = dest_addr_low_o;
        end
        `MCH_CMD_SET_API: begin
          if (rcr_has_param_i) p_api_next = rcr_param_i[7:0];
          val_next = {24'h000000, api_operation_setting_o};
        end
        `MCH_CMD_APPLY: apply_now = 1'b1;
        `MCH_CMD_WRITE_NV: begin
          nv_dh_next = p_dh_reg;
          nv_dl_next = p_dl_reg;
          nv_api_next = p_api_reg;
        end
        `MCH_CMD_SW_RESET: begin
          // Unsaved pending changes are lost across a reset
          a_dh_next = nv_dh_reg;
          a_dl_next = nv_dl_reg;
          a_api_next = nv_api_reg;
          p_dh_next = nv_dh_reg;
          p_dl_next = nv_dl_reg;
          p_api_next = nv_api_reg;
        end
        default: st_next = `MCH_ST_BAD_CMD;
      endcase
      if (rcr_apply_i && st_next == `MCH_ST_OK) apply_now = 1'b1;
      if (apply_now) begin
        a_dh_next = p_dh_next;
        a_dl_next = p_dl_next;
        a_api_next = p_api_next;
      end
    end
    // An aggregate match overrides the pending and active copies of the destination, not the saved one
    if (agg_hit) begin
      a_dh_next = agg_rx_src_i[63:32];
      a_dl_next = agg_rx_src_i[31:0];
      p_dh_next = agg_rx_src_i[63:32];
      p_dl_next = agg_rx_src_i[31:0];
    end
  end

  // Settings registers and remote response transmission
  always @(posedge clk_i) begin
    if (rst_i) begin
      p_dh_reg <= `MCH_DH_RST;
      p_dl_reg <= `MCH_DL_RST;
      p_api_reg <= `MCH_API_RST;
      nv_dh_reg <= `MCH_DH_RST;
      nv_dl_reg <= `MCH_DL_RST;
      nv_api_reg <= `MCH_API_RST;
      dest_addr_high_o <= `MCH_DH_RST;
      dest_addr_low_o <= `MCH_DL_RST;
      api_operation_setting_o <= `MCH_API_RST;
      rsp_tx_valid_o <= 1'b0;
      rsp_tx_dest_o <= 64'h0000000000000000;
      rsp_tx_frame_id_o <= 8'h00;
      rsp_tx_status_o <= 8'h00;
      rsp_tx_value_o <= 32'h00000000;
      ucast_target_valid_o <= 1'b0;
      ucast_target_o <= 64'h0000000000000000;
    end else begin
      p_dh_reg <= p_dh_next;
      p_dl_reg <= p_dl_next;
      p_api_reg <= p_api_next;
      nv_dh_reg <= nv_dh_next;
      nv_dl_reg <= nv_dl_next;
      nv_api_reg <= nv_api_next;
      dest_addr_high_o <= a_dh_next;
      dest_addr_low_o <= a_dl_next;
      api_operation_setting_o <= a_api_next;
      rsp_tx_valid_o <= rcr_valid_i && rcr_frame_id_i != `MCH_FID_NONE;
      if (rcr_valid_i) begin
        rsp_tx_dest_o <= rcr_src_i;
        rsp_tx_frame_id_o <= rcr_frame_id_i;
        rsp_tx_status_o <= st_next;
        rsp_tx_value_o <= val_next;
      end
      // Transparent operation unicasts to the active destination
      ucast_target_valid_o <= a_api_next == `MCH_API_RST;
      ucast_target_o <= {a_dh_next, a_dl_next};
    end
  end

  // Aggregate broadcast out, route install and host frames
  always @(posedge clk_i) begin
    if (rst_i) begin
      agg_tx_valid_o <= 1'b0;
      agg_tx_dest_o <= `MCH_BCAST_ADDR;
      agg_tx_param_o <= 64'h0000000000000000;
      route_wr_o <= 1'b0;
      route_dest_o <= 64'h0000000000000000;
      host_valid_o <= 1'b0;
      host_type_o <= 8'h00;
      host_frame_id_o <= 8'h00;
      host_status_o <= 8'h00;
      host_value_o <= 64'h0000000000000000;
    end else begin
      agg_tx_valid_o <= agg_cmd_valid_i;
      agg_tx_dest_o <= `MCH_BCAST_ADDR;
      if (agg_cmd_valid_i) agg_tx_param_o <= agg_cmd_param_i;
      // Route toward the sender is installed whether or not the address matched
      route_wr_o <= agg_rx_valid_i;
      if (agg_rx_valid_i) route_dest_o <= agg_rx_src_i;
      // One host frame per cycle; lower priority events in the same cycle are dropped
      host_valid_o <= 1'b0;
      if (rrsp_valid_i && !rrsp_unreachable_i) begin
        host_valid_o <= 1'b1;
        host_type_o <= `MCH_FT_REMOTE_RSP;
        host_frame_id_o <= rrsp_frame_id_i;
        host_status_o <= rrsp_status_i;
        host_value_o <= {32'h00000000, rrsp_value_i};
      end else if (agg_hit && api_operation_setting_o != `MCH_API_RST) begin
        host_valid_o <= 1'b1;
        host_type_o <= `MCH_FT_AGG_UPDATE;
        host_frame_id_o <= 8'h00;
        host_status_o <= `MCH_ST_OK;
        host_value_o <= agg_rx_src_i;
      end else if (ltr_valid_i && ltr_cluster_i == `MCH_CL_LT_RES && ltr_endpoint_i == `MCH_EP_DIAG) begin
        host_valid_o <= 1'b1;
        host_type_o <= `MCH_FT_EXPLICIT_RX;
        host_frame_id_o <= 8'h00;
        host_status_o <= `MCH_ST_OK;
        host_value_o <= ltr_src_i;
      end
    end
  end

  // Link test sequencer: collect request, send packets, average, report
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      req_reg <= 96'h0;
      nbytes_reg <= 4'h0;
      lt_dest_reg <= 64'h0000000000000000;
      lt_size_reg <= 16'h0000;
      lt_iter_reg <= 16'h0000;
      sent_reg <= 16'h0000;
      succ_reg <= 16'h0000;
      retry_reg <= 16'h0000;
      result_reg <= `MCH_RES_OK;
      peak_reg <= `MCH_RSSI_INIT_PEAK;
      low_reg <= `MCH_RSSI_INIT_LOW;
      mean_reg <= 8'h00;
      rssi_sum_reg <= 24'h000000;
      div_go_reg <= 1'b0;
      ser_load_reg <= 1'b0;
      tp_send_o <= 1'b0;
      tp_dest_o <= 64'h0000000000000000;
      tp_size_o <= 16'h0000;
      res_dest_o <= 64'h0000000000000000;
      res_cluster_o <= `MCH_CL_LT_RES;
      res_endpoint_o <= `MCH_EP_DIAG;
      busy_o <= 1'b0;
    end else begin
      tp_send_o <= 1'b0;
      div_go_reg <= 1'b0;
      ser_load_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (ltq_valid_i) begin
            req_reg <= req_full;
            nbytes_reg <= ltq_last_i ? 4'h0 : nbytes_reg + 4'h1;
          end
          if (ltq_hit && ltq_len_ok) begin
            lt_dest_reg <= req_full[`MCH_REQ_DEST];
            lt_size_reg <= req_full[`MCH_REQ_SIZE];
            lt_iter_reg <= req_full[`MCH_REQ_ITER];
            res_dest_o <= ltq_src_i;
            sent_reg <= 16'h0000;
            succ_reg <= 16'h0000;
            retry_reg <= 16'h0000;
            rssi_sum_reg <= 24'h000000;
            peak_reg <= `MCH_RSSI_INIT_PEAK;
            low_reg <= `MCH_RSSI_INIT_LOW;
            mean_reg <= 8'h00;
            busy_o <= 1'b1;
            if (iter_ok && size_ok) begin
              result_reg <= `MCH_RES_OK;
              state_reg <= S_SEND;
            end else begin
              // Bad request is reported at once, with no packets sent
              result_reg <= `MCH_RES_BAD_PARAM;
              ser_load_reg <= 1'b1;
              state_reg <= S_LOAD;
            end
          end
        end
        S_SEND: begin
          tp_send_o <= 1'b1;
          tp_dest_o <= lt_dest_reg;
          tp_size_o <= lt_size_reg;
          state_reg <= S_WAIT;
        end
        S_WAIT: begin
          if (tp_done_i) begin
            sent_reg <= sent_next;
            // Saturate rather than wrap on very lossy links
            retry_reg <= retry_sum[16] ? 16'hFFFF : retry_sum[15:0];
            if (tp_acked_i) begin
              succ_reg <= succ_reg + 16'h0001;
              rssi_sum_reg <= rssi_sum_reg + {16'h0000, tp_rssi_i};
              // Levels are magnitudes: a smaller byte is a stronger signal
              if (tp_rssi_i < peak_reg) peak_reg <= tp_rssi_i;
              if (tp_rssi_i > low_reg) low_reg <= tp_rssi_i;
            end
            if (sent_next == lt_iter_reg) begin
              div_go_reg <= 1'b1;
              state_reg <= S_DIV;
            end else begin
              state_reg <= S_SEND;
            end
          end
        end
        S_DIV: begin
          if (succ_reg == 16'h0000) begin
            ser_load_reg <= 1'b1;
            state_reg <= S_LOAD;
          end else if (div_done) begin
            mean_reg <= div_quo[7:0];
            ser_load_reg <= 1'b1;
            state_reg <= S_LOAD;
          end
        end
        S_LOAD: state_reg <= S_OUT;
        S_OUT: begin
          if (res_valid_o && res_ready_i && res_last_o) begin
            busy_o <= 1'b0;
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Average signal over acknowledged packets
  mch_divider #(
    .NW(24),
    .DW(16)
  ) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(div_go_reg),
    .num_i(rssi_sum_reg),
    .den_i(succ_reg),
    .done_o(div_done),
    .quo_o(div_quo)
  );

  // Result payload, sent most significant byte first
  mch_serializer #(
    .NBYTES(`MCH_LT_RES_BYTES)
  ) u_ser (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(ser_load_reg),
    .data_i({lt_dest_reg, lt_size_reg, lt_iter_reg, succ_reg, retry_reg,
             result_reg, mac_retry_limit_i, peak_reg, low_reg, mean_reg}),
    .ready_i(res_ready_i),
    .valid_o(res_valid_o),
    .byte_o(res_byte_o),
    .last_o(res_last_o)
  );
endmodule // mch_handler

//--- mch_handler_assertions.sv
module mch_handler_checker (
  // Clock and reset
  input logic clk_i,
  input logic rst_i,
  // Remote settings traffic
  input logic rcr_valid_i,
  input logic [7:0] rcr_frame_id_i,
  input logic rsp_tx_valid_o,
  input logic rrsp_valid_i,
  input logic rrsp_unreachable_i,
  input logic host_valid_o,
  input logic [7:0] host_type_o,
  // Aggregate routes
  input logic agg_cmd_valid_i,
  input logic agg_tx_valid_o,
  input logic [63:0] agg_tx_dest_o,
  input logic agg_rx_valid_i,
  input logic [63:0] agg_rx_src_i,
  input logic route_wr_o,
  input logic [63:0] route_dest_o,
  // Settings and result addressing
  input logic [7:0] api_operation_setting_o,
  input logic ucast_target_valid_o,
  input logic [15:0] res_cluster_o,
  input logic [7:0] res_endpoint_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Responses follow one cycle after a request, only for non-zero ids
  rsp_on_fid_a: assert property (rcr_valid_i && rcr_frame_id_i != 8'h00 |=> rsp_tx_valid_o)
    else $error("no response for non-zero id");
  rsp_muted_a: assert property (rcr_valid_i && rcr_frame_id_i == 8'h00 |=> !rsp_tx_valid_o)
    else $error("response sent for id zero");
  unreach_quiet_a: assert property (rrsp_valid_i && rrsp_unreachable_i |=> !(host_valid_o && host_type_o == 8'h80))
    else $error("host frame for unreachable target");
  rrsp_host_a: assert property (rrsp_valid_i && !rrsp_unreachable_i |=> host_valid_o && host_type_o == 8'h80)
    else $error("remote response not forwarded");
  agg_bcast_a: assert property (agg_cmd_valid_i |=> agg_tx_valid_o && agg_tx_dest_o == 64'h000000000000FFFF)
    else $error("aggregate not broadcast");
  route_wr_a: assert property (agg_rx_valid_i |=> route_wr_o && route_dest_o == $past(agg_rx_src_i))
    else $error("route toward sender missing");
  ucast_sel_a: assert property (!$past(rst_i) |-> ucast_target_valid_o == (api_operation_setting_o == 8'h00))
    else $error("unicast target selection wrong");
  res_port_a: assert property (res_cluster_o == 16'h0094 && res_endpoint_o == 8'hE6)
    else $error("result addressing wrong");
  cover property (rsp_tx_valid_o);
  cover property (route_wr_o);
  cover property (host_valid_o && host_type_o == 8'h8E);
endmodule // mch_handler_checker

bind mch_handler mch_handler_checker mch_handler_checker_inst (.*);

//--- mch_peer_model.sv
module mch_peer_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Test packet engine
  input wire logic send_i,
  output logic done_o = 1'b0,
  output logic acked_o = 1'b0,
  output logic [7:0] retries_o = 8'h00,
  output logic [7:0] rssi_o = 8'h00,
  // Result stream stall
  output logic ready_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_reg = 2'h0;
  logic [7:0] pkt_reg = 8'h00;
  // Fields mean nothing outside done, so they flip to expose stale sampling
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    ready_o <= ~ready_o | rst_i;
    acked_o <= ~acked_o;
    retries_o <= ~retries_o;
    rssi_o <= ~rssi_o;
    if (rst_i) begin
      wait_reg <= 2'h0;
      pkt_reg <= 8'h00;
    end else if (send_i) begin
      wait_reg <= 2'h3;
    end else if (wait_reg != 2'h0) begin
      wait_reg <= wait_reg - 2'h1;
      if (wait_reg == 2'h1) begin
        done_o <= 1'b1;
        acked_o <= 1'b1;
        retries_o <= pkt_reg;
        rssi_o <= 8'h52 + {pkt_reg[6:0], 1'b0};
        pkt_reg <= pkt_reg + 8'h01;
      end
    end
  end
endmodule // mch_peer_model

//--- tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, rcr_valid_i = 0, rcr_apply_i = 0, rcr_has_param_i = 1, rrsp_valid_i = 0;
  logic rrsp_unreachable_i = 0, agg_cmd_valid_i = 0, agg_rx_valid_i = 0, ltq_valid_i = 0, ltq_last_i = 0;
  logic ltr_valid_i = 0, tp_done_i, tp_acked_i, res_ready_i, rsp_tx_valid_o, host_valid_o, agg_tx_valid_o;
  logic route_wr_o, ucast_target_valid_o, tp_send_o, res_valid_o, res_last_o, busy_o;
  logic [2:0] rcr_cmd_i = '0;
  logic [7:0] rcr_frame_id_i = '0, rrsp_frame_id_i = '0, rrsp_status_i = '0, ltq_byte_i = '0, ltq_endpoint_i = '0;
  logic [7:0] ltr_endpoint_i = '0, mac_retry_limit_i = 8'h0A, tp_retries_i, tp_rssi_i, res_byte_o, res_endpoint_o;
  logic [7:0] rsp_tx_frame_id_o, rsp_tx_status_o, host_type_o, host_frame_id_o, host_status_o, api_operation_setting_o;
  logic [15:0] ltq_cluster_i = '0, ltr_cluster_i = '0, tp_size_o, res_cluster_o;
  logic [31:0] rcr_param_i = '0, rrsp_value_i = '0, rsp_tx_value_o, dest_addr_high_o, dest_addr_low_o;
  logic [63:0] rcr_src_i = '0, agg_cmd_param_i = '0, agg_rx_src_i = '0, agg_rx_param_i = '0, ltq_src_i = '0;
  logic [63:0] ltr_src_i = '0, rsp_tx_dest_o, host_value_o, agg_tx_dest_o, agg_tx_param_o, route_dest_o;
  logic [63:0] ucast_target_o, tp_dest_o, res_dest_o;
  logic [167:0] got;
  int bad_count = 0, check_count = 0, cyc = 0;
  mch_handler mch_handler_inst (.*);
  mch_peer_model mch_peer_model_inst (.clk_i, .rst_i, .send_i(tp_send_o), .done_o(tp_done_i), .acked_o(tp_acked_i),
    .retries_o(tp_retries_i), .rssi_o(tp_rssi_i), .ready_o(res_ready_i));
  // Clock and hang guard; the ceiling is far above the few hundred cycles needed
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      stop_test;
    end
  end
  task automatic check(input logic [167:0] seen, input logic [167:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Inputs change a fixed 1 ns after the edge so they never race the sampling
  task automatic step;
    @(posedge clk_i);
    #1;
  endtask
  task automatic rcr(input logic [7:0] fid, input logic [2:0] cmd, input logic ap, input logic [31:0] p);
    rcr_frame_id_i = fid;
    rcr_cmd_i = cmd;
    rcr_apply_i = ap;
    rcr_param_i = p;
    rcr_valid_i = 1; // Held high between back-to-back requests
    step;
  endtask
  task automatic agg(input logic [63:0] p, input logic [63:0] s);
    rcr_valid_i = 0;
    agg_rx_param_i = p;
    agg_rx_src_i = s;
    agg_rx_valid_i = 1;
    step;
    agg_rx_valid_i = 0;
  endtask
  // Sends a 12-byte request and collects the 21 result bytes as the far side accepts them
  task automatic lt(input logic [15:0] it);
    logic [95:0] req;
    int n;
    req = {64'h00000001_23456789, 16'h0028, it};
    ltq_src_i = 64'h00000003_00000ABC;
    ltq_cluster_i = 16'h0014;
    ltq_endpoint_i = 8'hE6;
    for (int i = 0; i < 12; i++) begin
      ltq_byte_i = req[95 - 8 * i -: 8];
      ltq_last_i = (i == 11);
      ltq_valid_i = 1;
      step;
    end
    ltq_valid_i = 0;
    n = 0;
    while (n < 21) begin
      if (res_valid_o && res_ready_i) begin
        got = {got[159:0], res_byte_o};
        n++;
      end
      step;
    end
    check(res_dest_o, ltq_src_i);
  endtask
  task automatic t_remote;
    step;
    check({dest_addr_high_o, dest_addr_low_o, ucast_target_valid_o}, {64'hFFFF, 1'b1});
    rcr(8'h05, 3'h2, 1'b1, 32'h1234);
    check({rsp_tx_valid_o, rsp_tx_frame_id_o, rsp_tx_status_o, rsp_tx_value_o, dest_addr_low_o},
      {17'h10500, 64'hFFFF_00001234});
    rcr(8'h00, 3'h1, 1'b0, 32'hAB);
    check({rsp_tx_valid_o, dest_addr_high_o}, 33'h0);
    rcr(8'h06, 3'h4, 1'b0, 32'h0);
    check(dest_addr_high_o, 32'hAB);
    rcr(8'h07, 3'h7, 1'b0, 32'h0);
    check({rsp_tx_status_o, ucast_target_o}, {8'h02, 64'hAB_00001234});
    rcr(8'h08, 3'h2, 1'b0, 32'h5555);
    rcr(8'h09, 3'h5, 1'b0, 32'h0);
    rcr(8'h0A, 3'h6, 1'b0, 32'h0);
    check(dest_addr_low_o, 32'h5555);
    rcr_valid_i = 0;
  endtask
  task automatic t_rrsp;
    rrsp_frame_id_i = 8'h09;
    rrsp_value_i = 32'hCAFE0001;
    rrsp_unreachable_i = 1;
    rrsp_valid_i = 1;
    step;
    check(host_valid_o, 1'b0);
    rrsp_unreachable_i = 0;
    step;
    rrsp_valid_i = 0;
    check({host_valid_o, host_type_o, host_frame_id_o, host_value_o}, {17'h18009, 64'hCAFE0001});
  endtask
  task automatic t_agg;
    agg_cmd_param_i = 64'h1234;
    agg_cmd_valid_i = 1;
    step;
    agg_cmd_valid_i = 0;
    check({agg_tx_valid_o, agg_tx_dest_o, agg_tx_param_o}, {1'b1, 64'hFFFF, 64'h1234});
    rcr(8'h0B, 3'h1, 1'b1, 32'h0);
    rcr(8'h0C, 3'h2, 1'b1, 32'hFFFE);
    rcr(8'h0D, 3'h3, 1'b1, 32'h1);
    agg(64'hFFFE, 64'h2_0000BEEF);
    check({host_valid_o, route_wr_o, route_dest_o, dest_addr_low_o}, {2'h1, 64'h2_0000BEEF, 32'hFFFE});
    rcr(8'h0E, 3'h2, 1'b1, 32'h1234);
    agg(64'h1234, 64'h2_0000BEEF);
    check({host_valid_o, host_type_o, host_value_o, dest_addr_high_o, dest_addr_low_o},
      {9'h18E, 64'h2_0000BEEF, 64'h2_0000BEEF});
    check(ucast_target_valid_o, 1'b0);
  endtask
  task automatic t_link;
    lt(16'h0003);
    check(got, {64'h1_23456789, 64'h0028_0003_0003_0003, 40'h00_0A_52_56_54});
    lt(16'h0FA1);
    check(got[39:32], 8'h03);
    ltr_cluster_i = 16'h0094;
    ltr_endpoint_i = 8'hE6;
    ltr_valid_i = 1;
    step;
    ltr_valid_i = 0;
    check({host_valid_o, host_type_o}, 9'h191);
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    #1;
    rst_i = 0;
    t_remote;
    t_rrsp;
    t_agg;
    t_link;
    stop_test;
  end
endmodule // tb_top
